// ===== sfpi_pins.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Chip select high: deselected, outputs released.
// - Deselected means standby unless internal cycle busy.
// - Chip select low: enabled and active power.
// - Input bits sampled on clock rising edges.
// - Output bits change on clock falling edges.
// - Multi-lane reads turn lane zero into output.
// - Lane zero ignored while chip select is high.
// - Dual reads keep lane one output, two bits.
// - Write-protect pin low with the pin lock code locks status; array only if a block protect bit is set.
// - Quad enable makes write-protect pin data lane two.
// - 65,536 pages; page program takes 256 bytes max.
// - Clock may idle low or high, modes 0/3.
// - Pause enters/leaves on pause edges with clock low.
// - Select high while paused resets; needs pause high, reselect.
module sfpi_pins
    import sfpi_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_cs_n,
    input  wire logic                  i_sck,
    input  wire logic [3:0]            i_io,
    output logic      [3:0]            o_io,
    output logic      [3:0]            o_io_oe_n,
    input  wire logic                  i_quad_enable_bit,
    input  wire logic [1:0]            i_status_lock_bits,
    input  wire logic                  i_block_protect_bit0,
    input  wire logic                  i_block_protect_bit1,
    input  wire logic                  i_block_protect_bit2,
    input  wire logic                  i_internal_busy,
    input  wire logic                  i_program_phase,
    input  wire logic [1:0]            i_out_lanes,
    input  wire logic                  i_tx_enable,
    input  wire logic                  i_tx_valid,
    input  wire logic [7:0]            i_tx_data,
    output logic                       o_tx_ready,
    output logic                       o_rx_valid,
    output logic      [7:0]            o_rx_data,
    output logic                       o_rx_first,
    input  wire logic                  i_rx_ready,
    input  wire logic                  i_clear_flags,
    output logic                       o_rx_overrun,
    output logic                       o_tx_underrun,
    output logic                       o_page_full,
    output logic                       o_frame_end,
    output logic                       o_selected,
    output logic                       o_active_mode,
    output logic                       o_standby_mode,
    output logic                       o_hold_active,
    output logic                       o_status_write_locked,
    output logic                       o_array_write_locked
);

    sfpi_core_type         s_reg;
    sfpi_core_type         s_next;
    logic [PIN_COUNT-1:0]  pins;
    logic                  cs_n;
    logic                  sck;
    logic                  hold;
    logic                  cs_fall;
    logic                  cs_rise;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  hold_fall;
    logic                  hold_rise;
    logic                  hold_en;
    logic                  push_valid;
    logic [RX_WIDTH-1:0]   push_data;
    logic                  push_ready;
    logic [RX_WIDTH-1:0]   pop_data;
    logic                  tx_take;
    logic [7:0]            cur_byte;
    logic [3:0]            step;
    logic [3:0]            lane_oe_n;
    logic [7:0]            done_byte;
    logic                  under_set;

    // Host pins pass two flip-flops first.
    sfpi_sync #(
        .WIDTH   (PIN_COUNT),
        .RST_VAL (PIN_IDLE)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_io, i_sck, i_cs_n}),
        .o_sync  (pins)
    );

    // Received bytes wait here; full refuses them.
    sfpi_fifo #(
        .WIDTH   (RX_WIDTH),
        .DEPTH   (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_valid (push_valid),
        .i_data  (push_data),
        .o_ready (push_ready),
        .o_valid (o_rx_valid),
        .o_data  (pop_data),
        .i_ready (i_rx_ready)
    );

    // Pin edges.
    assign cs_n      = pins[IDX_CS];
    assign sck       = pins[IDX_SCK];
    assign hold      = pins[IDX_IO3];
    assign hold_en   = !i_quad_enable_bit;
    assign cs_fall   = s_reg.cs_prev && !cs_n;
    assign cs_rise   = !s_reg.cs_prev && cs_n;
    assign sck_rise  = !s_reg.sck_prev && sck;
    assign sck_fall  = s_reg.sck_prev && !sck;
    assign hold_fall = hold_en && s_reg.hold_prev && !hold && !sck;
    assign hold_rise = hold_en && !s_reg.hold_prev && hold && !sck;
    assign done_byte = {s_reg.in_shift[6:0], pins[IDX_IO0]};

    // Output lane mode; quad needs quad enable.
    always_comb
    begin
        step      = STEP_SINGLE;
        lane_oe_n = OE_SINGLE;
        if (i_out_lanes == LANES_QUAD && i_quad_enable_bit)
        begin
            step      = STEP_QUAD;
            lane_oe_n = OE_QUAD;
        end
        else if (i_out_lanes == LANES_DUAL)
        begin
            step      = STEP_DUAL;
            lane_oe_n = OE_DUAL;
        end
    end

    // Next state.
    always_comb
    begin
        s_next           = s_reg;
        s_next.cs_prev   = cs_n;
        s_next.sck_prev  = sck;
        s_next.hold_prev = hold;
        s_next.frame_end = 1'b0;
        push_valid       = 1'b0;
        push_data        = {s_reg.first_byte, done_byte};
        tx_take          = 1'b0;
        cur_byte         = s_reg.out_shift;
        under_set        = 1'b0;

        case (s_reg.state)
            ST_IDLE:
            begin
                s_next.io_oe_n = OE_NONE;
                // A select fall starts a frame.
                if (cs_fall)
                begin
                    s_next.state      = ST_SHIFT;
                    s_next.seen_rise  = 1'b0;
                    s_next.in_cnt     = '0;
                    s_next.first_byte = 1'b1;
                    s_next.out_left   = '0;
                    s_next.page_cnt   = '0;
                end
            end
            ST_SHIFT:
            begin
                if (cs_rise)
                begin
                    s_next.state     = ST_IDLE;
                    s_next.io_oe_n   = OE_NONE;
                    s_next.frame_end = 1'b1;
                end
                else if (hold_fall)
                begin
                    s_next.state = ST_HOLD;
                end
                else
                begin
                    // Sample lane zero unless driven.
                    if (sck_rise && s_reg.io_oe_n[LANE0])
                    begin
                        s_next.seen_rise = 1'b1;
                        s_next.in_shift  = done_byte;
                        s_next.in_cnt    = s_reg.in_cnt + 1'b1;
                        if (s_reg.in_cnt == LAST_BIT)
                        begin
                            s_next.first_byte = 1'b0;
                            if (!s_reg.first_byte && i_program_phase)
                            begin
                                if (s_reg.page_cnt != PAGE_BYTES)
                                begin
                                    push_valid      = 1'b1;
                                    s_next.page_cnt = s_reg.page_cnt + 1'b1;
                                end
                            end
                            else
                            begin
                                push_valid = 1'b1;
                            end
                            if (push_valid && !push_ready)
                            begin
                                s_next.overrun = 1'b1;
                            end
                        end
                    end
                    else if (sck_rise)
                    begin
                        s_next.seen_rise = 1'b1;
                    end
                    // A falling edge before any rising edge is the mode 3 idle level.
                    if (sck_fall && s_reg.seen_rise && i_tx_enable)
                    begin
                        if (s_reg.out_left == '0)
                        begin
                            tx_take  = i_tx_valid;
                            cur_byte = i_tx_valid ? i_tx_data : FILL_BYTE;
                            if (!i_tx_valid)
                            begin
                                under_set = 1'b1;
                            end
                        end
                        s_next.io_oe_n = lane_oe_n;
                        s_next.io_out  = '1;
                        if (step == STEP_QUAD)
                        begin
                            s_next.io_out = cur_byte[7:4];
                        end
                        else if (step == STEP_DUAL)
                        begin
                            s_next.io_out[LANE1] = cur_byte[7];
                            s_next.io_out[LANE0] = cur_byte[6];
                        end
                        else
                        begin
                            s_next.io_out[LANE1] = cur_byte[7];
                        end
                        s_next.out_shift = cur_byte << step;
                        s_next.out_left  = ((s_reg.out_left == '0) ? FULL_LEFT : s_reg.out_left) - step;
                    end
                end
            end
            ST_HOLD:
            begin
                // Select high while paused drops the frame.
                if (cs_rise)
                begin
                    s_next.state     = ST_REARM;
                    s_next.io_oe_n   = OE_NONE;
                    s_next.frame_end = 1'b1;
                end
                else if (hold_rise)
                begin
                    s_next.state = ST_SHIFT;
                end
            end
            ST_REARM:
            begin
                s_next.io_oe_n = OE_NONE;
                if (cs_fall && (hold || !hold_en))
                begin
                    s_next.state      = ST_SHIFT;
                    s_next.seen_rise  = 1'b0;
                    s_next.in_cnt     = '0;
                    s_next.first_byte = 1'b1;
                    s_next.out_left   = '0;
                    s_next.page_cnt   = '0;
                end
            end
            default:
            begin
                s_next.state   = ST_IDLE;
                s_next.io_oe_n = OE_NONE;
            end
        endcase

        // Software clear loses to a new event in the same cycle.
        if (i_clear_flags)
        begin
            s_next.overrun  = (push_valid && !push_ready);
        end
        s_next.underrun = under_set || (s_reg.underrun && !i_clear_flags);

        // Power mode follows select and internal work.
        s_next.active = !cs_n || i_internal_busy;

        // Pin lock only outside quad mode.
        s_next.status_lock = !i_quad_enable_bit && !pins[IDX_IO2] && (i_status_lock_bits == LOCK_BY_PIN);
        s_next.array_lock  = s_next.status_lock &&
                             (i_block_protect_bit0 || i_block_protect_bit1 || i_block_protect_bit2);
    end

    // State register.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_reg           <= '0;
            s_reg.state     <= ST_IDLE;
            s_reg.cs_prev   <= 1'b1;
            s_reg.hold_prev <= 1'b1;
            s_reg.io_out    <= '1;
            s_reg.io_oe_n   <= OE_NONE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Pins are released outside an unpaused frame.
    assign o_io                  = s_reg.io_out;
    assign o_io_oe_n             = (s_reg.state == ST_SHIFT) ? s_reg.io_oe_n : OE_NONE;
    assign o_tx_ready            = tx_take;
    assign o_rx_data             = pop_data[7:0];
    assign o_rx_first            = pop_data[BYTE_BITS];
    assign o_rx_overrun          = s_reg.overrun;
    assign o_tx_underrun         = s_reg.underrun;
    assign o_page_full           = (s_reg.page_cnt == PAGE_BYTES);
    assign o_frame_end           = s_reg.frame_end;
    assign o_selected            = (s_reg.state == ST_SHIFT) || (s_reg.state == ST_HOLD);
    assign o_active_mode         = s_reg.active;
    assign o_standby_mode        = !s_reg.active;
    assign o_hold_active         = (s_reg.state == ST_HOLD);
    assign o_status_write_locked = s_reg.status_lock;
    assign o_array_write_locked  = s_reg.array_lock;

endmodule : sfpi_pins

// ===== sfpi_pkg.sv
package sfpi_pkg;

    // Pin positions in the synchroniser vector.
    localparam int unsigned PIN_COUNT = 6;
    localparam int unsigned IDX_CS    = 0;
    localparam int unsigned IDX_SCK   = 1;
    localparam int unsigned IDX_IO0   = 2;
    localparam int unsigned IDX_IO1   = 3;
    localparam int unsigned IDX_IO2   = 4;
    localparam int unsigned IDX_IO3   = 5;

    // Idle pins: select high, clock low, lanes high.
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 6'h3d;

    // Data lane numbers.
    localparam int unsigned LANE0 = 0;
    localparam int unsigned LANE1 = 1;
    localparam int unsigned LANE2 = 2;
    localparam int unsigned LANE3 = 3;

    // Serial framing.
    localparam int unsigned BYTE_BITS = 8;
    localparam logic [2:0]  LAST_BIT  = 3'h7;
    localparam logic [3:0]  FULL_LEFT = 4'h8;
    localparam logic [7:0]  FILL_BYTE = 8'hff;

    // Pages and bytes per page.
    localparam int unsigned PAGE_COUNT = 65536;
    localparam logic [8:0]  PAGE_BYTES = 9'h100;
    localparam int unsigned PAGE_ADDR_BITS = $clog2(PAGE_COUNT);

    // Receive word: first-byte flag and byte.
    localparam int unsigned RX_WIDTH   = 9;
    localparam int unsigned FIFO_DEPTH = 16;

    // Output enables, active low, per lane mode.
    localparam logic [3:0] OE_NONE   = 4'hf;
    localparam logic [3:0] OE_SINGLE = 4'hd;
    localparam logic [3:0] OE_DUAL   = 4'hc;
    localparam logic [3:0] OE_QUAD   = 4'h0;

    // Bits moved per falling edge.
    localparam logic [3:0] STEP_SINGLE = 4'h1;
    localparam logic [3:0] STEP_DUAL   = 4'h2;
    localparam logic [3:0] STEP_QUAD   = 4'h4;

    // Lock code that arms the pin lock.
    localparam logic [1:0] LOCK_BY_PIN = 2'h1;

    // Output lane selection.
    typedef enum logic [1:0] {
        LANES_SINGLE = 2'h0,
        LANES_DUAL   = 2'h1,
        LANES_QUAD   = 2'h2
    } sfpi_lanes_type;

    // Interface states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SHIFT = 4'h2,
        ST_HOLD  = 4'h4,
        ST_REARM = 4'h8
    } sfpi_state_type;

    // Pin interface state.
    typedef struct packed {
        sfpi_state_type state;
        logic           cs_prev;
        logic           sck_prev;
        logic           hold_prev;
        logic           seen_rise;
        logic [7:0]     in_shift;
        logic [2:0]     in_cnt;
        logic           first_byte;
        logic [7:0]     out_shift;
        logic [3:0]     out_left;
        logic [3:0]     io_out;
        logic [3:0]     io_oe_n;
        logic [8:0]     page_cnt;
        logic           overrun;
        logic           underrun;
        logic           frame_end;
        logic           active;
        logic           status_lock;
        logic           array_lock;
    } sfpi_core_type;

endpackage : sfpi_pkg

// ===== sfpi_sync.sv
`timescale 1ns/1ps

module sfpi_sync
    import sfpi_pkg::*;
#(
    parameter int unsigned         WIDTH   = 1,
    parameter logic [WIDTH-1:0]    RST_VAL = '0
)(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sfpi_sync_type;

    sfpi_sync_type s_reg;
    sfpi_sync_type s_next;

    // Stage one feeds only stage two.
    always_comb
    begin
        s_next.meta   = i_async;
        s_next.stable = s_reg.meta;
    end

    // Reset to the idle pin level.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_reg <= '{meta: RST_VAL, stable: RST_VAL};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign o_sync = s_reg.stable;

endmodule : sfpi_sync

// ===== sfpi_fifo.sv
`timescale 1ns/1ps

module sfpi_fifo
    import sfpi_pkg::*;
#(
    parameter int unsigned WIDTH = RX_WIDTH,
    parameter int unsigned DEPTH = FIFO_DEPTH
)(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    output logic                  o_valid,
    output logic      [WIDTH-1:0] o_data,
    input  wire logic             i_ready
);

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } sfpi_fifo_type;

    sfpi_fifo_type    s_reg;
    sfpi_fifo_type    s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             full;
    logic             empty;

    // Full: pointers differ only in wrap bit.
    assign full    = (s_reg.wr_ptr[AW] != s_reg.rd_ptr[AW]) && (s_reg.wr_ptr[AW-1:0] == s_reg.rd_ptr[AW-1:0]);
    assign empty   = (s_reg.wr_ptr == s_reg.rd_ptr);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[s_reg.rd_ptr[AW-1:0]];

    // Pointers advance per transfer.
    always_comb
    begin
        s_next = s_reg;
        if (i_valid && !full)
        begin
            s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
        end
        if (i_ready && !empty)
        begin
            s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
        end
    end

    // Pointer registers.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Storage has no reset; empty guards it.
    always_ff @(posedge i_clk)
    begin
        if (i_valid && !full)
        begin
            mem[s_reg.wr_ptr[AW-1:0]] <= i_data;
        end
    end

endmodule : sfpi_fifo

// ===== sfpi_chk.sv
`timescale 1ns/1ps

// Checks the pin interface ports.
module sfpi_chk
    import sfpi_pkg::*;
(
    input wire logic       i_clk, i_rst, i_cs_n, i_internal_busy, i_quad_enable_bit, i_tx_valid, i_rx_ready,
    input wire logic [1:0] i_status_lock_bits,
    input wire logic [3:0] i_io, o_io_oe_n,
    input wire logic       o_selected, o_hold_active, o_frame_end, o_active_mode, o_standby_mode,
    input wire logic       o_tx_ready, o_rx_valid, o_status_write_locked
);
    // Block clock; idle during reset.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Levels tied to the pins that cause them.
    a_desel_released: assert property (i_cs_n [*6] |-> o_io_oe_n == 4'hf)
        else $error("driven deselected");
    a_idle_released: assert property (!o_selected |-> o_io_oe_n == 4'hf)
        else $error("driven outside frame");
    a_cs_ends_frame: assert property (i_cs_n [*6] |-> !o_selected)
        else $error("frame open deselected");
    a_standby_power: assert property ((i_cs_n && !i_internal_busy) [*5] |-> o_standby_mode && !o_active_mode)
        else $error("no standby");
    a_busy_active: assert property (i_internal_busy [*5] |-> o_active_mode)
        else $error("busy not active");
    a_select_active: assert property (!i_cs_n [*5] |-> o_active_mode)
        else $error("select not active");
    a_hold_released: assert property (o_hold_active |-> o_io_oe_n == 4'hf)
        else $error("driven while paused");
    a_frame_close: assert property (o_frame_end |=> !o_frame_end && !o_selected)
        else $error("bad frame end");
    a_tx_pulse: assert property (o_tx_ready |-> i_tx_valid ##1 !o_tx_ready)
        else $error("take without offer");
    a_pin_lock: assert property ((!i_quad_enable_bit && i_status_lock_bits == 2'h1 && !i_io[2]) [*5]
        |-> o_status_write_locked)
        else $error("no pin lock");
    a_quad_unlock: assert property ((i_status_lock_bits == 2'h1 && (i_quad_enable_bit || i_io[2])) [*5]
        |-> !o_status_write_locked)
        else $error("stray lock");

    // Scenarios.
    c_hold: cover property (o_hold_active);
    c_frame_end: cover property (o_frame_end);
    c_pop: cover property (o_rx_valid && i_rx_ready);
    c_tx: cover property (o_tx_ready);
endmodule : sfpi_chk

// ===== sfpi_host.sv
`timescale 1ns/1ps

// Host model: select, clock and lanes.
module sfpi_host
    import sfpi_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [3:0] i_io,
    output logic            o_cs_n,
    output logic            o_sck,
    output logic      [3:0] o_io,
    output logic      [3:0] o_io_oe_n
);
    logic cpol;

    // Deselected; lane one left to the device.
    initial
    begin
        cpol      = 1'b0;
        o_cs_n    = 1'b1;
        o_sck     = 1'b0;
        o_io      = 4'hf;
        o_io_oe_n = 4'h2;
    end

    // Opens a frame at the clock's idle level.
    task automatic start(input logic mode3);
        @(negedge i_clk) #1;
        cpol  = mode3;
        o_sck = mode3;
        #100 o_cs_n = 1'b0;
        #100;
    endtask : start

    // Moves one byte: drive after each fall, read at each rise.
    task automatic xfer(input logic [7:0] tx, input int w, output logic [7:0] rx);
        int b;
        @(negedge i_clk) #1;
        o_io_oe_n = {(w == 4) ? 2'h3 : 2'h0, 1'b1, w != 1};
        for (b = 7; b >= 0; b -= w)
        begin
            o_sck   = 1'b0;
            o_io[0] = tx[b];
            #62.5 o_sck = 1'b1;
            if (w == 1) rx[b] = i_io[1];
            else if (w == 2) rx[b -: 2] = i_io[1:0];
            else rx[b -: 4] = i_io;
            #62.5;
        end
    endtask : xfer

    // Clock to idle, then select high.
    task automatic stop;
        @(negedge i_clk) #1;
        o_sck = cpol;
        #62.5 o_cs_n = 1'b1;
        o_io_oe_n = 4'h2;
        #200;
    endtask : stop

    // Sets lane k with the clock low.
    task automatic lane(input int k, input logic l);
        @(negedge i_clk) #1;
        o_sck = 1'b0;
        #62.5 o_io[k] = l;
        #200;
    endtask : lane
endmodule : sfpi_host

// ===== sfpi_pins_test.sv
`timescale 1ns/1ps

module sfpi_pins_test
    import sfpi_pkg::*;
;
    logic       i_clk, i_rst, i_cs_n, i_sck, i_quad_enable_bit, i_block_protect_bit0, i_internal_busy;
    logic       i_program_phase, i_tx_enable, i_tx_valid, i_rx_ready, i_clear_flags, o_tx_ready, o_rx_valid;
    logic       o_rx_first, o_rx_overrun, o_tx_underrun, o_page_full, o_frame_end, o_selected, o_active_mode;
    logic       o_standby_mode, o_hold_active, o_status_write_locked, o_array_write_locked;
    logic       i_block_protect_bit1 = 1'b0, i_block_protect_bit2 = 1'b0;
    logic [1:0] i_status_lock_bits, i_out_lanes;
    logic [7:0] i_tx_data, o_rx_data, got;
    logic [3:0] dut_io, dut_oe_n, h_io, h_oe_n, io_w;
    int         errors, check_count, pops, i, w;

    // Device first, then host, else pull-up.
    assign io_w = (~dut_oe_n & dut_io) | (dut_oe_n & ~h_oe_n & h_io) | (dut_oe_n & h_oe_n);

    sfpi_pins dut (.*, .i_io(io_w), .o_io(dut_io), .o_io_oe_n(dut_oe_n));
    sfpi_host host (.i_clk, .i_io(io_w), .o_cs_n(i_cs_n), .o_sck(i_sck), .o_io(h_io), .o_io_oe_n(h_oe_n));

    // Block clock and count of popped bytes.
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_rx_valid && i_rx_ready) pops++;

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: got %h, wanted %h", $time, g, e);
        end
    endtask : chk8

    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask : chk1

    task automatic settle;
        repeat (8) @(negedge i_clk);
    endtask : settle

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // Checks and pops the buffer head.
    task automatic pop(input logic [7:0] e, input logic f);
        int n;
        @(negedge i_clk);
        for (n = 0; n < 400 && o_rx_valid !== 1'b1; n++) @(negedge i_clk);
        if (n == 400)
        begin
            errors++;
            $display("unexpected at %0t: no byte", $time);
            finish_test();
        end
        chk8(o_rx_data, e);
        chk1(o_rx_first, f);
        i_rx_ready = 1'b1;
        @(negedge i_clk);
        i_rx_ready = 1'b0;
    endtask : pop

    // Tests.
    initial
    begin
        {i_quad_enable_bit, i_block_protect_bit0, i_internal_busy, i_program_phase} = 4'h0;
        {i_tx_enable, i_tx_valid, i_rx_ready, i_clear_flags, i_status_lock_bits, i_out_lanes} = 8'h00;
        i_tx_data = 8'hc3;
        i_rst = 1'b1;
        repeat (16) @(negedge i_clk);
        i_rst = 1'b0;
        host.xfer(8'h96, 1, got);
        settle();
        chk1(o_rx_valid, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            host.start(i[0]);
            chk1(o_active_mode, 1'b1);
            host.xfer(8'ha5, 1, got);
            host.xfer(8'h3c, 1, got);
            host.stop();
            chk1(o_standby_mode, 1'b1);
            pop(8'ha5, 1'b1);
            pop(8'h3c, 1'b0);
        end
        i_internal_busy = 1'b1;
        settle();
        chk1(o_active_mode, 1'b1);
        i_internal_busy = 1'b0;
        done("input and power");
        i_tx_valid = 1'b1;
        for (w = 1; w <= 4; w *= 2)
        begin
            i_out_lanes = w[2:1];
            i_quad_enable_bit = w[2];
            host.start(1'b0);
            host.xfer(8'h6b, 1, got);
            @(negedge i_clk);
            i_tx_enable = 1'b1;
            host.xfer(8'h00, w, got);
            chk8(got, 8'hc3);
            @(negedge i_clk);
            i_tx_valid = !w[0];
            host.xfer(8'h00, w, got);
            chk8(got, w[0] ? FILL_BYTE : 8'hc3);
            @(negedge i_clk);
            {i_tx_enable, i_tx_valid} = 2'h1;
            host.stop();
            pop(8'h6b, 1'b1);
            repeat ((w == 1) ? 2 : 0) pop(8'h00, 1'b0);
        end
        {i_quad_enable_bit, i_out_lanes} = 3'h0;
        done("reads");
        host.start(1'b0);
        for (i = 0; i < 18; i++) host.xfer(i[7:0], 1, got);
        host.stop();
        chk1(o_rx_overrun, 1'b1);
        chk1(o_tx_underrun, 1'b1);
        for (i = 0; i < 16; i++) pop(i[7:0], i == 0);
        chk1(o_rx_valid, 1'b0);
        i_clear_flags = 1'b1;
        settle();
        i_clear_flags = 1'b0;
        chk1(o_rx_overrun, 1'b0);
        chk1(o_tx_underrun, 1'b0);
        done("buffer");
        {i_program_phase, i_rx_ready} = 2'h3;
        pops = 0;
        host.start(1'b0);
        for (i = 0; i < 259; i++) host.xfer(i[7:0], 1, got);
        chk1(o_page_full, 1'b1);
        host.stop();
        settle();
        chk1(pops == 257, 1'b1);
        {i_program_phase, i_rx_ready} = 2'h0;
        done("page");
        host.start(1'b0);
        host.xfer(8'he7, 1, got);
        host.lane(3, 1'b0);
        chk1(o_hold_active, 1'b1);
        host.lane(3, 1'b1);
        chk1(o_hold_active, 1'b0);
        host.xfer(8'h81, 1, got);
        host.lane(3, 1'b0);
        host.stop();
        chk1(o_selected, 1'b0);
        host.start(1'b0);
        chk1(o_selected, 1'b0);
        host.stop();
        host.lane(3, 1'b1);
        host.start(1'b0);
        host.xfer(8'h42, 1, got);
        host.stop();
        pop(8'he7, 1'b1);
        pop(8'h81, 1'b0);
        pop(8'h42, 1'b1);
        done("pause");
        {i_status_lock_bits, i_block_protect_bit0} = 3'h3;
        host.lane(2, 1'b0);
        settle();
        chk1(o_status_write_locked, 1'b1);
        chk1(o_array_write_locked, 1'b1);
        {i_block_protect_bit0, i_block_protect_bit1} = 2'h1;
        settle();
        chk1(o_array_write_locked, 1'b1);
        {i_block_protect_bit1, i_block_protect_bit2} = 2'h1;
        settle();
        chk1(o_array_write_locked, 1'b1);
        i_block_protect_bit2 = 1'b0;
        settle();
        chk1(o_array_write_locked, 1'b0);
        i_quad_enable_bit = 1'b1;
        settle();
        chk1(o_status_write_locked, 1'b0);
        done("locks");
        finish_test();
    end
endmodule : sfpi_pins_test

bind sfpi_pins sfpi_chk chk (.*);
